// file: pkg/sfd_consts.svh
// Constants for the serial flash command front end
`ifndef SFD_CONSTS_SVH
`define SFD_CONSTS_SVH

`define SFD_OP_SET_WEL    8'h06
`define SFD_OP_CLR_WEL    8'h04
`define SFD_OP_RD_IDENT   8'h9f
`define SFD_OP_RD_STATUS  8'h05
`define SFD_OP_WR_LOCK    8'he5
`define SFD_OP_WR_STATUS  8'h01
`define SFD_OP_RD_LOCK    8'he8
`define SFD_OP_RD_ARRAY   8'h03
`define SFD_OP_RD_FAST    8'h0b
`define SFD_OP_PG_REWRITE 8'h0a
`define SFD_OP_PG_BURN    8'h02
`define SFD_OP_PG_CLEAR   8'hdb
`define SFD_OP_SUB_CLEAR  8'h20
`define SFD_OP_SEC_CLEAR  8'hd8
`define SFD_OP_ALL_CLEAR  8'hc7
`define SFD_OP_SLEEP      8'hb9
`define SFD_OP_WAKE       8'hab

`define SFD_ADDR_W        20
`define SFD_PAGE_MASK     20'hfff00
`define SFD_SUB_MASK      20'hff000
`define SFD_SEC_MASK      20'hf0000
`define SFD_PAGE_BYTES    9'h100
`define SFD_ADDR_LAST     3'h3
`define SFD_DUMMY_LAST    3'h4
`define SFD_ID_LAST       3'h2
`define SFD_BYTE_SAT      3'h7

`define SFD_ST_WIP        0
`define SFD_ST_WEL        1
`define SFD_ST_BP_LO      2
`define SFD_ST_SRWD       7

`endif

// file: pkg/sfd_pkg.sv
// Types shared by the serial flash command front end
package sfd_pkg;

  typedef enum logic [4:0] {
    cmd_none,
    set_write_latch_cmd,
    clear_write_latch_cmd,
    read_ident_cmd,
    read_status_cmd,
    write_status_cmd,
    write_lock_cmd,
    read_lock_cmd,
    array_read_cmd,
    fast_read_cmd,
    page_rewrite_cmd,
    page_burn_cmd,
    page_clear_cmd,
    small_block_clear_cmd,
    block_clear_cmd,
    whole_array_clear_cmd,
    deep_sleep_cmd,
    wake_from_sleep_cmd
  } sfd_kind_t;

  typedef enum logic [1:0] {
    mode_none,
    mode_replace,
    mode_and,
    mode_ones
  } sfd_mode_t;

  typedef struct packed {
    sfd_kind_t  kind;
    logic [2:0] need;
    logic       wel_req;
    logic       array;
  } sfd_dec_t;

  typedef struct packed {
    sfd_kind_t   kind;
    sfd_mode_t   mode;
    logic [19:0] addr;
    logic [7:0]  data;
    logic [8:0]  count;
  } sfd_exec_t;

endpackage : sfd_pkg

// file: design/sfd_sync.sv
// Two-stage synchroniser for a bundle of levels
module sfd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    meta <= d_i;
    q_o  <= meta;
  end

endmodule : sfd_sync

// file: design/sfd_opdec.sv
// Opcode decoder: kind, bytes needed and class of one opcode
`include "sfd_consts.svh"

module sfd_opdec (
  input  wire logic [7:0]      opcode_i,
  output sfd_pkg::sfd_dec_t    dec_o
);

  always_comb
  begin
    dec_o = '{sfd_pkg::cmd_none, 3'h0, 1'b0, 1'b0};
    case (opcode_i)
      `SFD_OP_SET_WEL:    dec_o = '{sfd_pkg::set_write_latch_cmd, 3'h1, 1'b0, 1'b0};
      `SFD_OP_CLR_WEL:    dec_o = '{sfd_pkg::clear_write_latch_cmd, 3'h1, 1'b0, 1'b0};
      `SFD_OP_WR_STATUS:  dec_o = '{sfd_pkg::write_status_cmd, 3'h2, 1'b0, 1'b0};
      `SFD_OP_RD_IDENT:   dec_o = '{sfd_pkg::read_ident_cmd, 3'h1, 1'b0, 1'b1};
      `SFD_OP_RD_STATUS:  dec_o = '{sfd_pkg::read_status_cmd, 3'h1, 1'b0, 1'b0};
      `SFD_OP_RD_ARRAY:   dec_o = '{sfd_pkg::array_read_cmd, 3'h4, 1'b0, 1'b1};
      `SFD_OP_RD_FAST:    dec_o = '{sfd_pkg::fast_read_cmd, 3'h5, 1'b0, 1'b1};
      `SFD_OP_WR_LOCK:    dec_o = '{sfd_pkg::write_lock_cmd, 3'h5, 1'b1, 1'b1};
      `SFD_OP_RD_LOCK:    dec_o = '{sfd_pkg::read_lock_cmd, 3'h4, 1'b0, 1'b1};
      `SFD_OP_PG_REWRITE: dec_o = '{sfd_pkg::page_rewrite_cmd, 3'h5, 1'b1, 1'b1};
      `SFD_OP_PG_BURN:    dec_o = '{sfd_pkg::page_burn_cmd, 3'h5, 1'b1, 1'b1};
      `SFD_OP_PG_CLEAR:   dec_o = '{sfd_pkg::page_clear_cmd, 3'h4, 1'b1, 1'b1};
      `SFD_OP_SUB_CLEAR:  dec_o = '{sfd_pkg::small_block_clear_cmd, 3'h4, 1'b1, 1'b1};
      `SFD_OP_SEC_CLEAR:  dec_o = '{sfd_pkg::block_clear_cmd, 3'h4, 1'b1, 1'b1};
      `SFD_OP_ALL_CLEAR:  dec_o = '{sfd_pkg::whole_array_clear_cmd, 3'h1, 1'b1, 1'b1};
      `SFD_OP_SLEEP:      dec_o = '{sfd_pkg::deep_sleep_cmd, 3'h1, 1'b0, 1'b0};
      `SFD_OP_WAKE:       dec_o = '{sfd_pkg::wake_from_sleep_cmd, 3'h1, 1'b0, 1'b0};
      default:            dec_o = '{sfd_pkg::cmd_none, 3'h0, 1'b0, 1'b0};
    endcase
  end

endmodule : sfd_opdec

// file: design/sfd_cmd_front.sv
// Serial flash command front end: link shifter, decoder and executor
// Summary of operation
// - Array is 4096 pages of 256 bytes, 1,048,576 bytes, 20-bit byte address.
// - Sixteen 64 KiB sectors; sector n has upper four address bits n.
// - 256 subsectors of 4 KiB, sixteen per sector, subsector 0 at 00000h-00FFFh.
// - Program clears bits only, erase sets bits only, page write sets either.
// - Erase at page, sector and whole-array size returns bits to one.
// - Opcode, address and data move most significant bit first both ways.
// - Input sampled from first rising clock after select falls, opcode bits in order.
// - Read-type commands shift data out; host may end after any output bit.
// - Modifying, enabling, erase and sleep commands run only on byte-aligned select rise.
// - Array access during a busy internal cycle is ignored; cycle continues.
// - 06h sets write latch, 04h clears it, 01h writes status with one byte.
// - 9Fh reads identification, 05h reads status repeatedly; no address bytes.
// - 03h reads with three address bytes; 0Bh adds one dummy byte.
// - E5h writes lock, E8h reads lock; three address bytes, one data byte.
// - 0Ah page rewrite and 02h page burn take address then 1 to 256 bytes.
// - DBh, 20h, D8h erase with address; C7h erases whole array.
// - B9h enters deep sleep, ABh wakes; neither takes operands.
// - Rewrite, burn, erase and lock write need the write latch set.
// - Whole-array erase runs only while all three protect bits are zero.
`include "sfd_consts.svh"

module sfd_cmd_front #(
  parameter logic [7:0] ID_BYTE0 = 8'h5a,  // Arbitrary identification value
  parameter logic [7:0] ID_BYTE1 = 8'ha5,  // Arbitrary identification value
  parameter logic [7:0] ID_BYTE2 = 8'h3c   // Arbitrary identification value
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                link_clk_i,
  input  wire logic                cs_n_i,
  input  wire logic                din_i,
  output logic                     dout_o,
  output logic                     dout_oe_n_o,
  input  wire logic                busy_i,
  input  wire logic [2:0]          prot_bits_i,
  input  wire logic                srwd_i,
  output logic [19:0]              rd_addr_o,
  output logic                     rd_lock_o,
  input  wire logic [7:0]          rd_data_i,
  output logic                     pbuf_we_o,
  output logic [7:0]               pbuf_idx_o,
  output logic [7:0]               pbuf_data_o,
  output logic                     exec_vld_o,
  output sfd_pkg::sfd_exec_t       exec_o,
  output logic                     reject_o,
  output logic                     write_enable_latch_o,
  output logic                     deep_sleep_o
);

  // Link domain state
  logic                fresh;
  logic                frame_tog;
  logic [2:0]          bit_cnt;
  logic [2:0]          byte_cnt;
  logic [7:0]          sh;
  sfd_pkg::sfd_kind_t  kind;
  logic [2:0]          need;
  logic                wel_req;
  logic                ign;
  logic [19:0]         addr;
  logic [19:0]         ptr;
  logic [7:0]          wbyte;
  logic [8:0]          wcnt;
  logic [7:0]          tx;
  logic                out_en;
  logic [7:0]          sh_full;
  logic [19:0]         full_addr;
  logic                byte_done;
  logic                load;
  logic [7:0]          load_val;
  logic                wdata_done;
  sfd_pkg::sfd_dec_t   dec;
  logic [6:0]          st_l;
  logic [7:0]          status_byte;
  sfd_pkg::sfd_kind_t  kind_now;
  logic                ign_new;
  logic                ign_now;

  // System domain state
  logic [1:0]          sys_s;
  logic                cs_d;
  logic                tog_seen;
  logic                cs_rise;
  logic                frame_ok;
  logic                mod_ok;
  logic                write_status_cmd_ok;
  logic                sleep_ok;
  logic                wake_ok;
  logic                wel_set_ok;
  logic                wel_clr_ok;
  logic                is_read;
  sfd_pkg::sfd_exec_t  next_exec;

  assign sh_full   = {sh[6:0], din_i};
  assign full_addr = {addr[11:0], sh_full};
  assign byte_done = !fresh && (bit_cnt == 3'h7);

  sfd_opdec u_dec (
    .opcode_i (sh_full),
    .dec_o    (dec)
  );

  // Status bits reach the link side within the opcode byte
  sfd_sync #(
    .W (7)
  ) u_sync_link (
    .clk_i (link_clk_i),
    .d_i   ({deep_sleep_o, srwd_i, prot_bits_i, write_enable_latch_o, busy_i}),
    .q_o   (st_l)
  );

  assign status_byte = {st_l[5], 2'b00, st_l[4:2], st_l[1], st_l[0]};

  assign ign_new  = (dec.kind == sfd_pkg::cmd_none)
                    || (st_l[0] && dec.array)
                    || (st_l[6] && dec.kind != sfd_pkg::wake_from_sleep_cmd);

  // Opcode byte answers from the decoder; its register only lands on that same edge
  assign kind_now = (byte_cnt == 3'h0) ? dec.kind : kind;
  assign ign_now  = (byte_cnt == 3'h0) ? ign_new : ign;

  // Select high holds the frame-start flag; link clock may be stopped
  always_ff @(posedge link_clk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
      fresh <= 1'b1;
    else
      fresh <= 1'b0;
  end

  // One toggle per frame, seen by the system side as a new-frame event
  always_ff @(posedge link_clk_i or posedge rst_i)
  begin
    if (rst_i)
      frame_tog <= 1'b0;
    else if (fresh)
      frame_tog <= ~frame_tog;
  end

  // Bit and byte counting from the first rising edge after select
  always_ff @(posedge link_clk_i)
  begin
    if (fresh)
    begin
      bit_cnt  <= 3'h1;
      byte_cnt <= 3'h0;
      sh       <= {7'h00, din_i};
    end
    else
    begin
      bit_cnt <= bit_cnt + 3'h1;
      sh      <= sh_full;
      if (byte_done && byte_cnt != `SFD_BYTE_SAT)
        byte_cnt <= byte_cnt + 3'h1;
    end
  end

  // Opcode capture; first whole byte of every frame is the opcode
  always_ff @(posedge link_clk_i)
  begin
    if (fresh)
    begin
      kind    <= sfd_pkg::cmd_none;
      need    <= 3'h0;
      wel_req <= 1'b0;
      ign     <= 1'b0;
    end
    else if (byte_done && byte_cnt == 3'h0)
    begin
      kind    <= dec.kind;
      need    <= dec.need;
      wel_req <= dec.wel_req;
      ign     <= ign_new;
    end
  end

  // Address bytes; upper four of 24 sent bits are dropped
  always_ff @(posedge link_clk_i)
  begin
    if (byte_done && byte_cnt != 3'h0 && byte_cnt <= `SFD_ADDR_LAST)
      addr <= full_addr;
  end

  // Single data byte of status or lock write
  always_ff @(posedge link_clk_i)
  begin
    if (byte_done && ((kind == sfd_pkg::write_status_cmd && byte_cnt == 3'h1)
        || (kind == sfd_pkg::write_lock_cmd && byte_cnt == `SFD_DUMMY_LAST)))
      wbyte <= sh_full;
  end

  assign wdata_done = byte_done && !ign && byte_cnt >= `SFD_DUMMY_LAST
                      && (kind == sfd_pkg::page_rewrite_cmd || kind == sfd_pkg::page_burn_cmd);

  // Page data goes straight to the page buffer, wrapping in-page; count holds at 256, so every later byte lands on the start index
  always_ff @(posedge link_clk_i)
  begin
    if (fresh)
      wcnt <= 9'h000;
    else if (wdata_done && wcnt != `SFD_PAGE_BYTES)
      wcnt <= wcnt + 9'h001;
  end

  always_ff @(posedge link_clk_i)
  begin
    pbuf_we_o   <= wdata_done;
    pbuf_idx_o  <= addr[7:0] + wcnt[7:0];
    pbuf_data_o <= sh_full;
  end

  // Output byte selection for every read-type command
  always_comb
  begin
    load     = 1'b0;
    load_val = 8'h00;
    if (byte_done && !ign_now)
    begin
      unique case (kind_now)
        sfd_pkg::read_status_cmd:
        begin
          load     = 1'b1;
          load_val = status_byte;
        end
        sfd_pkg::read_ident_cmd:
        begin
          load     = 1'b1;
          load_val = (byte_cnt == 3'h0) ? ID_BYTE0 :
                     (byte_cnt == 3'h1) ? ID_BYTE1 :
                     (byte_cnt == `SFD_ID_LAST) ? ID_BYTE2 : 8'h00;
        end
        sfd_pkg::array_read_cmd:
        begin
          load     = byte_cnt >= `SFD_ADDR_LAST;
          load_val = rd_data_i;
        end
        sfd_pkg::fast_read_cmd:
        begin
          load     = byte_cnt >= `SFD_DUMMY_LAST;
          load_val = rd_data_i;
        end
        sfd_pkg::read_lock_cmd:
        begin
          load     = byte_cnt >= `SFD_ADDR_LAST;
          load_val = (byte_cnt == `SFD_ADDR_LAST) ? rd_data_i : 8'h00;
        end
        default:
        begin
          load     = 1'b0;
          load_val = 8'h00;
        end
      endcase
    end
  end

  // Plain read needs its byte on the edge that completes the address
  assign rd_addr_o = (byte_done && byte_cnt == `SFD_ADDR_LAST) ? full_addr : ptr;
  assign rd_lock_o = (kind == sfd_pkg::read_lock_cmd);

  // Read pointer rolls over at the top of the array
  always_ff @(posedge link_clk_i)
  begin
    if (byte_done && byte_cnt == `SFD_ADDR_LAST)
      ptr <= load ? full_addr + 20'h00001 : full_addr;
    else if (load)
      ptr <= ptr + 20'h00001;
  end

  always_ff @(posedge link_clk_i)
  begin
    if (load)
      tx <= load_val;
    else if (out_en)
      tx <= {tx[6:0], 1'b0};
  end

  always_ff @(posedge link_clk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
      out_en <= 1'b0;
    else if (load)
      out_en <= 1'b1;
  end

  // Drive on falling edges; releasing on select rise ends output at any bit
  always_ff @(negedge link_clk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      dout_o      <= 1'b0;
      dout_oe_n_o <= 1'b1;
    end
    else
    begin
      dout_o      <= tx[7];
      dout_oe_n_o <= !out_en;
    end
  end

  // System side: select and frame toggle cross as levels
  sfd_sync #(
    .W (2)
  ) u_sync_sys (
    .clk_i (clk_i),
    .d_i   ({cs_n_i, frame_tog}),
    .q_o   (sys_s)
  );

  assign cs_rise = sys_s[1] && !cs_d;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cs_d     <= 1'b1;
      tog_seen <= 1'b0;
    end
    else
    begin
      cs_d <= sys_s[1];
      if (cs_rise)
        tog_seen <= sys_s[0];
    end
  end

  // Link registers are still after select rises, so read them as they stand
  assign frame_ok   = cs_rise && (sys_s[0] != tog_seen) && !ign && kind != sfd_pkg::cmd_none
                      && bit_cnt == 3'h0 && byte_cnt >= need;
  assign is_read    = kind == sfd_pkg::read_status_cmd || kind == sfd_pkg::read_ident_cmd
                      || kind == sfd_pkg::array_read_cmd || kind == sfd_pkg::fast_read_cmd
                      || kind == sfd_pkg::read_lock_cmd;
  assign mod_ok     = frame_ok && wel_req && write_enable_latch_o && !busy_i && !deep_sleep_o
                      && !(kind == sfd_pkg::whole_array_clear_cmd && prot_bits_i != 3'h0);
  assign write_status_cmd_ok    = frame_ok && kind == sfd_pkg::write_status_cmd && !busy_i && !deep_sleep_o;
  assign sleep_ok   = frame_ok && kind == sfd_pkg::deep_sleep_cmd;
  assign wake_ok    = frame_ok && kind == sfd_pkg::wake_from_sleep_cmd;
  assign wel_set_ok = frame_ok && kind == sfd_pkg::set_write_latch_cmd && !deep_sleep_o;
  assign wel_clr_ok = frame_ok && kind == sfd_pkg::clear_write_latch_cmd && !deep_sleep_o;

  // Write latch; a later accepted command wins only by its own clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      write_enable_latch_o <= 1'b0;
    else if (wel_set_ok)
      write_enable_latch_o <= 1'b1;
    else if (wel_clr_ok || mod_ok)
      write_enable_latch_o <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      deep_sleep_o <= 1'b0;
    else if (sleep_ok)
      deep_sleep_o <= 1'b1;
    else if (wake_ok)
      deep_sleep_o <= 1'b0;
  end

  // Command record for the write engine
  always_comb
  begin
    next_exec       = '0;
    next_exec.kind  = kind;
    next_exec.data  = wbyte;
    next_exec.count = wcnt;
    next_exec.addr  = addr;
    next_exec.mode  = sfd_pkg::mode_replace;
    unique case (kind)
      sfd_pkg::page_burn_cmd:         next_exec.mode = sfd_pkg::mode_and;
      sfd_pkg::page_clear_cmd:
      begin
        next_exec.mode = sfd_pkg::mode_ones;
        next_exec.addr = addr & `SFD_PAGE_MASK;
      end
      sfd_pkg::small_block_clear_cmd:
      begin
        next_exec.mode = sfd_pkg::mode_ones;
        next_exec.addr = addr & `SFD_SUB_MASK;
      end
      sfd_pkg::block_clear_cmd:
      begin
        next_exec.mode = sfd_pkg::mode_ones;
        next_exec.addr = addr & `SFD_SEC_MASK;
      end
      sfd_pkg::whole_array_clear_cmd:
      begin
        next_exec.mode = sfd_pkg::mode_ones;
        next_exec.addr = 20'h00000;
      end
      default:                        next_exec.mode = sfd_pkg::mode_replace;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      exec_vld_o <= 1'b0;
      exec_o     <= '0;
      reject_o   <= 1'b0;
    end
    else
    begin
      exec_vld_o <= mod_ok || write_status_cmd_ok;
      if (mod_ok || write_status_cmd_ok)
        exec_o <= next_exec;
      // Any completed non-read frame with a decoded opcode that did nothing is flagged
      reject_o <= cs_rise && (sys_s[0] != tog_seen) && kind != sfd_pkg::cmd_none && !is_read
                  && !(mod_ok || write_status_cmd_ok || sleep_ok || wake_ok || wel_set_ok || wel_clr_ok);
    end
  end

endmodule : sfd_cmd_front

// file: sim/sfd_cmd_front_checker.sv
// Port assertions for the serial flash command front end
module sfd_cmd_front_checker (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               cs_n_i,
  input wire logic               busy_i,
  input wire logic [2:0]         prot_bits_i,
  input wire logic               dout_oe_n_o,
  input wire logic               exec_vld_o,
  input wire sfd_pkg::sfd_exec_t exec_o,
  input wire logic               reject_o,
  input wire logic               write_enable_latch_o,
  input wire logic               deep_sleep_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sfd_pkg::sfd_kind_t k;
  logic               ers;
  logic               mdf;
  assign k = exec_o.kind;
  assign ers = exec_vld_o && (k == sfd_pkg::page_clear_cmd || k == sfd_pkg::small_block_clear_cmd
               || k == sfd_pkg::block_clear_cmd || k == sfd_pkg::whole_array_clear_cmd);
  // Modifying accepts are the ones that consume the latch
  assign mdf = ers || (exec_vld_o && (k == sfd_pkg::page_burn_cmd || k == sfd_pkg::page_rewrite_cmd
               || k == sfd_pkg::write_lock_cmd));
  one_outcome_a: assert property (!(exec_vld_o && reject_o))
    else $error("accept and reject together");
  accept_pulse_a: assert property (exec_vld_o |=> !exec_vld_o)
    else $error("accept longer than one cycle");
  idle_release_a: assert property (cs_n_i && $past(cs_n_i) |-> dout_oe_n_o)
    else $error("output driven while deselected");
  latch_used_a: assert property (mdf |-> $past(write_enable_latch_o) && !write_enable_latch_o)
    else $error("modify without latch or latch kept");
  busy_block_a: assert property (mdf |-> !busy_i)
    else $error("modify accepted while busy");
  bulk_prot_a: assert property (exec_vld_o && k == sfd_pkg::whole_array_clear_cmd |-> prot_bits_i == 3'h0)
    else $error("whole erase with protect bits set");
  erase_ones_a: assert property (ers |-> exec_o.mode == sfd_pkg::mode_ones)
    else $error("erase mode wrong");
  burn_and_a: assert property (exec_vld_o && k == sfd_pkg::page_burn_cmd |-> exec_o.mode == sfd_pkg::mode_and)
    else $error("program mode wrong");
  sector_align_a: assert property (exec_vld_o && k == sfd_pkg::block_clear_cmd |-> exec_o.addr[15:0] == 16'h0)
    else $error("sector address not aligned");
  sub_align_a: assert property (exec_vld_o && k == sfd_pkg::small_block_clear_cmd |-> exec_o.addr[11:0] == 12'h0)
    else $error("subsector address not aligned");
  sleep_cause_a: assert property ($changed(deep_sleep_o) |-> cs_n_i && $past(cs_n_i, 2))
    else $error("sleep changed inside a frame");
endmodule : sfd_cmd_front_checker

bind sfd_cmd_front sfd_cmd_front_checker i_sfd_cmd_front_checker (.clk_i, .rst_i, .cs_n_i, .busy_i, .prot_bits_i,
  .dout_oe_n_o, .exec_vld_o, .exec_o, .reject_o, .write_enable_latch_o, .deep_sleep_o);

// file: sim/sfd_host_model.sv
// Host serial controller model driving the link side
module sfd_host_model (
  output logic      link_clk_o,
  output logic      cs_n_o,
  output logic      din_o,
  input  wire logic dout_i
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    link_clk_o = 1'b0;
    din_o = 1'b1;
    // Select edge clears the link side, which has no other reset apart from frame_tog on rst_i
    cs_n_o = 1'b0;
    #1 cs_n_o = 1'b1;
  end
  // Clock stands low between frames; gap covers the resync time
  task automatic xfer(input logic [63:0] tx, input int nbits, input int ncmd, output logic [63:0] rx);
    rx = '0;
    cs_n_o = 1'b0;
    #50;
    for (int i = 0; i < nbits; i++)
    begin
      din_o = tx[63 - i];
      #7.5 link_clk_o = 1'b1;
      if (i >= ncmd)
        rx = {rx[62:0], dout_i};
      #7.5 link_clk_o = 1'b0;
    end
    #7.5 cs_n_o = 1'b1;
    din_o = ~din_o;
    #600;
  endtask : xfer
endmodule : sfd_host_model

// file: sim/sfd_cmd_front_tb.sv
// Self-checking bench for the serial flash command front end
module sfd_cmd_front_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic               clk_i, rst_i, link_clk_i, cs_n_i, din_i, dout_o, dout_oe_n_o, busy_i, srwd_i;
  logic               rd_lock_o, pbuf_we_o, exec_vld_o, reject_o, write_enable_latch_o, deep_sleep_o;
  logic [2:0]         prot_bits_i;
  logic [7:0]         rd_data_i, pbuf_idx_o, pbuf_data_o, d;
  logic [19:0]        rd_addr_o, a;
  logic [63:0]        rx;
  sfd_pkg::sfd_exec_t exec_o, last;
  int                 n_errors, n_checks, n_acc, n_rej, cyc;
  logic [7:0]         ops [6] = '{8'hdb, 8'h20, 8'hd8, 8'hc7, 8'h02, 8'h0a};
  int                 nbs [6] = '{32, 32, 32, 8, 48, 48};
  logic [19:0]        msk [6] = '{20'hfff00, 20'hff000, 20'hf0000, 20'h0, 20'hfffff, 20'hfffff};
  sfd_pkg::sfd_kind_t kd [6] = '{sfd_pkg::page_clear_cmd, sfd_pkg::small_block_clear_cmd,
    sfd_pkg::block_clear_cmd, sfd_pkg::whole_array_clear_cmd, sfd_pkg::page_burn_cmd, sfd_pkg::page_rewrite_cmd};
  sfd_pkg::sfd_mode_t md [6] = '{sfd_pkg::mode_ones, sfd_pkg::mode_ones, sfd_pkg::mode_ones,
    sfd_pkg::mode_ones, sfd_pkg::mode_and, sfd_pkg::mode_replace};
  function automatic logic [7:0] arr(input logic [19:0] x);
    return x[7:0] ^ x[15:8];
  endfunction : arr
  function automatic logic [63:0] op(input logic [7:0] c, input logic [19:0] x, input logic [15:0] dd);
    return {c, 4'h0, x, dd, 16'h0};
  endfunction : op
  // Storage stand-in: lock bytes differ from array bytes
  assign rd_data_i = rd_lock_o ? rd_addr_o[7:0] ^ 8'h96 : arr(rd_addr_o);
  sfd_cmd_front i_sfd_cmd_front (.clk_i, .rst_i, .link_clk_i, .cs_n_i, .din_i, .dout_o, .dout_oe_n_o, .busy_i,
    .prot_bits_i, .srwd_i, .rd_addr_o, .rd_lock_o, .rd_data_i, .pbuf_we_o, .pbuf_idx_o, .pbuf_data_o,
    .exec_vld_o, .exec_o, .reject_o, .write_enable_latch_o, .deep_sleep_o);
  // Data line pulled up while the device lets go of it
  sfd_host_model i_sfd_host_model (.link_clk_o(link_clk_i), .cs_n_o(cs_n_i), .din_o(din_i),
    .dout_i(dout_oe_n_o ? 1'b1 : dout_o));
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  always @(posedge clk_i)
  begin
    cyc++;
    if (exec_vld_o === 1'b1)
      last = exec_o;
    n_acc += (exec_vld_o === 1'b1);
    n_rej += (reject_o === 1'b1);
    if (cyc > 5000)
    begin
      n_errors++;
      finish_test();
    end
  end
  task automatic check(input string nm, input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic drive(input logic b, input logic [2:0] p, input logic s);
    @(posedge clk_i);
    #1;
    busy_i = b;
    prot_bits_i = p;
    srwd_i = s;
    repeat (3) @(posedge clk_i);
  endtask : drive
  // Outcome 0 none, 1 write engine accept, 2 refused
  task automatic frame(input logic [63:0] tx, input int nb, input int nc, input int res);
    int a0, r0;
    a0 = n_acc;
    r0 = n_rej;
    i_sfd_host_model.xfer(tx, nb, nc, rx);
    check("accepted", n_acc - a0, res == 1);
    check("refused", n_rej - r0, res == 2);
  endtask : frame
  initial
  begin
    rst_i = 1'b1;
    busy_i = 1'b0;
    prot_bits_i = 3'h0;
    srwd_i = 1'b0;
    void'($urandom(32'haaa6));
    repeat (12) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    repeat (4) @(posedge clk_i);
    check("latch", write_enable_latch_o, 1'b0);
    check("sleep", deep_sleep_o, 1'b0);
    check("oe_n", dout_oe_n_o, 1'b1);
    frame(op(8'h06, 0, 0), 8, 64, 0);
    check("latch", write_enable_latch_o, 1'b1);
    frame(op(8'h04, 0, 0), 8, 64, 0);
    check("latch", write_enable_latch_o, 1'b0);
    drive(1'b0, 3'($urandom), 1'($urandom));
    frame(op(8'h05, 0, 0), 24, 8, 0);
    check("status", rx[15:0], {2{srwd_i, 2'b00, prot_bits_i, 2'b00}});
    frame(op(8'h9f, 0, 0), 40, 8, 0);
    check("ident", rx[31:0], 32'h5aa53c00);
    a = 20'($urandom);
    a[7:0] = 8'hff;
    frame(op(8'h03, a, 0), 48, 32, 0);
    check("read", rx[15:0], {arr(a), arr(a + 20'h1)});
    frame(op(8'h0b, a, 0), 56, 40, 0);
    check("fast", rx[15:0], {arr(a), arr(a + 20'h1)});
    frame(op(8'he8, a, 0), 48, 32, 0);
    check("lock", rx[15:0], {a[7:0] ^ 8'h96, 8'h00});
    drive(1'b0, 3'h0, 1'b0);
    for (int k = 0; k < 6; k++)
    begin
      a = 20'($urandom);
      d = 8'($urandom);
      frame(op(8'h06, 0, 0), 8, 64, 0);
      frame(op(ops[k], a, {d, ~d}), nbs[k], 64, 1);
      check("kind", last.kind, kd[k]);
      check("addr", last.addr, a & msk[k]);
      check("mode", last.mode, md[k]);
      check("latch", write_enable_latch_o, 1'b0);
      if (k > 3)
      begin
        check("count", last.count, 9'h2);
        check("pbuf", {pbuf_we_o, pbuf_idx_o, pbuf_data_o}, {1'b1, a[7:0] + 8'h1, ~d});
      end
    end
    frame(op(8'hd8, a, 0), 32, 64, 2);
    frame(op(8'h06, 0, 0), 8, 64, 0);
    frame(op(8'hd8, a, 0), 31, 64, 2);
    drive(1'b0, 3'h1, 1'b0);
    frame(op(8'hc7, 0, 0), 8, 64, 2);
    drive(1'b1, 3'h0, 1'b0);
    frame(op(8'hd8, a, 0), 32, 64, 2);
    frame(op(8'h03, a, 0), 48, 32, 0);
    check("busy read", rx[15:0], 16'hffff);
    drive(1'b0, 3'h0, 1'b0);
    check("latch", write_enable_latch_o, 1'b1);
    frame(op(8'hff, 0, 0), 24, 8, 0);
    check("unknown", rx[15:0], 16'hffff);
    frame(op(8'hb9, 0, 0), 8, 64, 0);
    check("sleep", deep_sleep_o, 1'b1);
    frame(op(8'h04, 0, 0), 8, 64, 2);
    frame(op(8'hab, 0, 0), 8, 64, 0);
    check("sleep", deep_sleep_o, 1'b0);
    d = 8'($urandom);
    frame({8'h01, d, 48'h0}, 16, 64, 1);
    check("status write", {last.kind, last.data}, {sfd_pkg::write_status_cmd, d});
    frame(op(8'he5, a, {d, 8'h0}), 40, 64, 1);
    check("lock write", {last.kind, last.addr, last.data}, {sfd_pkg::write_lock_cmd, a, d});
    finish_test();
  end
endmodule : sfd_cmd_front_tb
